// [core/uartfe_pkg.sv]
// Package of register offsets, field positions, reset values and timing counts
package uartfe_pkg;
   // Register offsets within the eight-byte window
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_IEN = 3'h1;
   localparam logic [2:0] OFS_IDENT = 3'h2;
   localparam logic [2:0] OFS_LCR = 3'h3;
   localparam logic [2:0] OFS_MCR = 3'h4;
   localparam logic [2:0] OFS_LSR = 3'h5;
   localparam logic [2:0] OFS_MSR = 3'h6;
   localparam logic [2:0] OFS_SCR = 3'h7;
   // Field positions
   localparam int LCR_DIVISOR_LATCH_SELECT = 7;
   localparam int LCR_BREAK = 6;
   localparam int LCR_STICK = 5;
   localparam int LCR_EVEN = 4;
   localparam int LCR_PEN = 3;
   localparam int LCR_STOP = 2;
   localparam int MCR_GATE = 3;
   localparam int MCR_LOOP = 4;
   localparam int IEN_RDA = 0;
   localparam int IEN_THRE = 1;
   localparam int IEN_RLS = 2;
   localparam int IEN_MSI = 3;
   localparam int QC_EN = 0;
   localparam int QC_RXCLR = 1;
   localparam int QC_TXCLR = 2;
   // Reset values
   localparam logic [7:0] LCR_RST = 8'h03;
   localparam logic [15:0] DIV_RST = 16'h0001;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [3:0] IEN_MASK = 4'hF;
   // Interrupt identification codes
   localparam logic [3:0] ID_NONE = 4'h1;
   localparam logic [3:0] ID_RLS = 4'h6;
   localparam logic [3:0] ID_RDA = 4'h4;
   localparam logic [3:0] ID_TMO = 4'hC;
   localparam logic [3:0] ID_THRE = 4'h2;
   localparam logic [3:0] ID_MSI = 4'h0;
   // Timing
   localparam int OVERSAMPLE = 16;
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [5:0] TMO_CHARS = 6'h28;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 8;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11,
      TX_STOP = 2'b10} uartfe_tx_t;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
      RX_STOP = 2'b10} uartfe_rx_t;
endpackage

// [core/uartfe_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module uartfe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic clr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [$clog2(DEPTH):0] level_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, rp_r;
   logic [AW:0] cnt_r;
   wire push = wr_valid_in && wr_ready_out;
   wire pop = rd_valid_out && rd_ready_in;
   // Full and empty come from the count, so they are always honest
   assign wr_ready_out = (cnt_r != DEPTH[AW:0]);
   assign rd_valid_out = (cnt_r != '0);
   assign rd_data_out = mem_r[rp_r];
   assign level_out = cnt_r;
   // Pointers and count
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || clr_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
   // Storage
   always_ff @(posedge ref_clk_in) begin
      if (push) mem_r[wp_r] <= wr_data_in;
   end
endmodule
`default_nettype wire

// [core/uartfe_top.sv]
// UART register front end with baud generator, transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module uartfe_top
   import uartfe_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic tx_out,
   input wire logic rx_in,
   input wire logic cts_n_in,
   input wire logic dsr_n_in,
   input wire logic ri_n_in,
   input wire logic dcd_n_in,
   output logic rts_n_out,
   output logic dtr_n_out,
   output logic irq_out
);
   import uartfe_pkg::*;

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [7:0] lcr_r, mcr_r, scr_r, rbr_r, thr_r;
   logic [3:0] ien_r;
   logic [15:0] div_r;
   logic qen_r, thr_full_r, dr_r, oe_r, pe_r, fe_r, bi_r, thre_ev_r;
   logic [3:0] msr_d_r, mdm_r;
   logic tmo_r;
   logic [7:0] rdata_r;
   logic [3:0] iir_code;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire divisor_latch_select = lcr_r[LCR_DIVISOR_LATCH_SELECT];
   wire sel_data = (addr_in == OFS_DATA);
   wire sel_dll = sel_data && divisor_latch_select;
   wire sel_dlm = (addr_in == OFS_IEN) && divisor_latch_select;
   wire sel_buf = sel_data && !divisor_latch_select;
   wire sel_ien = (addr_in == OFS_IEN) && !divisor_latch_select;
   wire wr_thr = wr_in && sel_buf;
   wire rd_rbr = rd_in && sel_buf;
   wire rd_lsr = rd_in && (addr_in == OFS_LSR);
   wire rd_msr = rd_in && (addr_in == OFS_MSR);
   wire rd_iir = rd_in && (addr_in == OFS_IDENT);
   wire qc_wr = wr_in && (addr_in == OFS_IDENT);
   wire qc_rxclr = (qc_wr && (wdata_in[QC_RXCLR] || !wdata_in[QC_EN]));
   wire qc_txclr = (qc_wr && (wdata_in[QC_TXCLR] || !wdata_in[QC_EN]));

   // ----------------------------------------
   // Baud generator
   // ----------------------------------------
   logic [15:0] bcnt_r;
   // rate set by this block's own divisor
   // programmable divide, zero treated as one
   wire [15:0] div_eff = (div_r == 16'h0000) ? DIV_RST : div_r;
   wire tick = (bcnt_r == 16'h0001);
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || tick) bcnt_r <= div_eff;
      else bcnt_r <= bcnt_r - 16'h0001;
   end

   // ----------------------------------------
   // Format helpers
   // ----------------------------------------
   // data length decode
   function automatic logic [3:0] data_len(input logic [1:0] wls);
      return 4'd5 + {2'b00, wls};
   endfunction
   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
      logic p;
      p = ^(d & (8'hFF >> (3'd3 - lc[1:0])));
      if (lc[LCR_STICK]) return !lc[LCR_EVEN];
      return lc[LCR_EVEN] ? p : !p;
   endfunction
   wire [3:0] nbits = data_len(lcr_r[1:0]);
   // stop length in ticks: 16, 24 for five bits, else 32
   wire [5:0] stop_ticks = !lcr_r[LCR_STOP] ? 6'd16 :
      (lcr_r[1:0] == 2'b00) ? 6'd24 : 6'd32;

   // ----------------------------------------
   // Transmit FIFO
   // ----------------------------------------
   logic [7:0] txq_d;
   logic txq_v, txq_rdy, tx_take;
   logic [3:0] txq_lvl;
   // Holding writes feed the queue in queue mode; the shifter drains it
   uartfe_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_txq (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .clr_in(qc_txclr),
      .wr_data_in(wdata_in),
      .wr_valid_in(wr_thr && qen_r),
      .wr_ready_out(txq_rdy),
      .rd_data_out(txq_d),
      .rd_valid_out(txq_v),
      .rd_ready_in(tx_take && qen_r),
      .level_out(txq_lvl)
   );
   wire tx_avail = qen_r ? txq_v : thr_full_r;
   wire [7:0] tx_word = qen_r ? txq_d : thr_r;

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   uartfe_tx_t tx_st_r;
   logic [7:0] tsr_r;
   logic [5:0] tt_r;
   logic [3:0] tb_r;
   logic tpar_r, tx_r;
   wire tbit_end = tick && (tt_r[3:0] == TICK_LAST);
   assign tx_take = (tx_st_r == TX_IDLE) && tx_avail && tick;
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         tx_st_r <= TX_IDLE;
         tsr_r <= ZERO8;
         tt_r <= '0;
         tb_r <= '0;
         tpar_r <= 1'b0;
         tx_r <= 1'b1;
      end else begin
         case (tx_st_r)
            TX_IDLE: begin
               tx_r <= 1'b1;
               if (tx_take) begin
                  tsr_r <= tx_word;
                  tpar_r <= par_bit(tx_word, lcr_r);
                  tt_r <= '0;
                  tx_r <= 1'b0;
                  tx_st_r <= TX_START;
               end
            end
            TX_START: begin
               if (tick) tt_r <= tt_r + 6'd1;
               if (tbit_end) begin
                  tt_r <= '0;
                  tb_r <= '0;
                  tx_r <= tsr_r[0];
                  tx_st_r <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tick) tt_r <= tt_r + 6'd1;
               if (tbit_end) begin
                  tt_r <= '0;
                  tb_r <= tb_r + 4'd1;
                  tsr_r <= {1'b0, tsr_r[7:1]};
                  if (tb_r + 4'd1 == nbits + {3'b000, lcr_r[LCR_PEN]}) begin
                     tx_r <= 1'b1;
                     tx_st_r <= TX_STOP;
                  end else if (tb_r + 4'd1 == nbits) begin
                     tx_r <= tpar_r;
                  end else begin
                     tx_r <= tsr_r[1];
                  end
               end
            end
            TX_STOP: begin
               if (tick) tt_r <= tt_r + 6'd1;
               if (tick && (tt_r + 6'd1 == stop_ticks)) tx_st_r <= TX_IDLE;
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end
   // Break forces spacing; loopback holds the line marking
   assign tx_out = mcr_r[MCR_LOOP] ? 1'b1 : (tx_r && !lcr_r[LCR_BREAK]);

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   uartfe_rx_t rx_st_r;
   logic [7:0] rsr_r;
   logic [3:0] rt_r, rb_r;
   logic rpar_r, rx_done;
   wire rx_line = mcr_r[MCR_LOOP] ? (tx_r && !lcr_r[LCR_BREAK]) : rx_in;
   wire rmid = tick && (rt_r == TICK_MID);
   wire [3:0] rtotal = nbits + {3'b000, lcr_r[LCR_PEN]};
   // Parity is taken over the aligned word, so short characters check the right bits
   wire rx_perr = lcr_r[LCR_PEN] && (rpar_r != par_bit(rx_word, lcr_r));
   // hidden shifter assembles LSB first, aligned down at the end
   wire [7:0] rx_word = rsr_r >> (4'd8 - nbits);
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rx_st_r <= RX_IDLE;
         rsr_r <= ZERO8;
         rt_r <= '0;
         rb_r <= '0;
         rpar_r <= 1'b0;
      end else begin
         if (tick) rt_r <= rt_r + 4'd1;
         case (rx_st_r)
            RX_IDLE: if (tick && !rx_line) begin
               rt_r <= '0;
               rx_st_r <= RX_START;
            end
            RX_START: if (rmid) begin
               rt_r <= TICK_MID + 4'd1;
               rb_r <= '0;
               rx_st_r <= rx_line ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rmid) begin
               rb_r <= rb_r + 4'd1;
               if (rb_r < nbits) rsr_r <= {rx_line, rsr_r[7:1]};
               else rpar_r <= rx_line;
               if (rb_r + 4'd1 == rtotal) rx_st_r <= RX_STOP;
            end
            RX_STOP: if (rmid) rx_st_r <= RX_IDLE;
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end
   assign rx_done = (rx_st_r == RX_STOP) && rmid;
   wire rx_fe = rx_done && !rx_line;
   wire rx_bi = rx_fe && (rsr_r == ZERO8);

   // ----------------------------------------
   // Receive FIFO
   // ----------------------------------------
   logic [7:0] rxq_d;
   logic rxq_v, rxq_rdy;
   logic [3:0] rxq_lvl;
   // Full queue refuses the character, which becomes an overrun
   uartfe_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_rxq (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .clr_in(qc_rxclr),
      .wr_data_in(rx_word),
      .wr_valid_in(rx_done && qen_r),
      .wr_ready_out(rxq_rdy),
      .rd_data_out(rxq_d),
      .rd_valid_out(rxq_v),
      .rd_ready_in(rd_rbr && qen_r),
      .level_out(rxq_lvl)
   );
   wire rx_ovr = rx_done && (qen_r ? !rxq_rdy : dr_r);

   // ----------------------------------------
   // Character timeout, four characters of idle with data held
   // ----------------------------------------
   logic [9:0] tmo_cnt_r;
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || !qen_r || !rxq_v || rx_done || rd_rbr) begin
         tmo_cnt_r <= '0;
         tmo_r <= 1'b0;
      end else if (tick && !tmo_r) begin
         tmo_cnt_r <= tmo_cnt_r + 10'd1;
         if (tmo_cnt_r[9:4] == TMO_CHARS) tmo_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Host register writes
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         lcr_r <= LCR_RST;
         mcr_r <= ZERO8;
         scr_r <= ZERO8;
         thr_r <= ZERO8;
         ien_r <= '0;
         div_r <= DIV_RST;
         qen_r <= 1'b0;
      end else if (wr_in) begin
         if (addr_in == OFS_LCR) lcr_r <= wdata_in;
         if (addr_in == OFS_MCR) mcr_r <= {3'b000, wdata_in[4:0]};
         if (addr_in == OFS_SCR) scr_r <= wdata_in;
         if (qc_wr) qen_r <= wdata_in[QC_EN];
         // only the low four enable bits are stored
         if (sel_ien) ien_r <= wdata_in[3:0] & IEN_MASK;
         if (sel_dll) div_r[7:0] <= wdata_in;
         if (sel_dlm) div_r[15:8] <= wdata_in;
         if (wr_thr) thr_r <= wdata_in;
      end
   end

   // ----------------------------------------
   // Status flags; a setting event wins over a clearing read
   // ----------------------------------------
   wire [3:0] mdm_now = ~{dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};
   // Ring indicator counts only its trailing edge
   wire [3:0] mdm_chg = (mdm_now ^ mdm_r) & {1'b1, ~mdm_now[2], 2'b11};
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         thr_full_r <= 1'b0;
         rbr_r <= ZERO8;
         dr_r <= 1'b0;
         {oe_r, pe_r, fe_r, bi_r} <= '0;
         msr_d_r <= '0;
         mdm_r <= '0;
         thre_ev_r <= 1'b0;
      end else begin
         mdm_r <= mdm_now;
         if (wr_thr && !qen_r) thr_full_r <= 1'b1;
         else if (tx_take && !qen_r) thr_full_r <= 1'b0;
         if (rx_done && !qen_r) begin
            rbr_r <= rx_word;
            dr_r <= 1'b1;
         end else if (rd_rbr) begin
            dr_r <= 1'b0;
         end
         // status keeps updating regardless of enables
         oe_r <= rx_ovr || (oe_r && !rd_lsr);
         pe_r <= (rx_done && rx_perr) || (pe_r && !rd_lsr);
         fe_r <= rx_fe || (fe_r && !rd_lsr);
         bi_r <= rx_bi || (bi_r && !rd_lsr);
         msr_d_r <= mdm_chg | (msr_d_r & {4{!rd_msr}});
         // Holding-empty event clears on write or on reading it as the source
         if (tx_take) thre_ev_r <= 1'b1;
         else if (wr_thr || (rd_iir && (iir_code == ID_THRE))) thre_ev_r <= 1'b0;
      end
   end
   wire rx_ready = qen_r ? rxq_v : dr_r;
   wire thr_empty = qen_r ? !txq_v : !thr_full_r;
   wire tsr_empty = thr_empty && (tx_st_r == TX_IDLE);
   wire [7:0] lsr = {qen_r && (pe_r || fe_r || bi_r), tsr_empty, thr_empty,
      bi_r, fe_r, pe_r, oe_r, rx_ready};

   // ----------------------------------------
   // Interrupt priority and output
   // ----------------------------------------
   wire trig_hit = (rxq_lvl >= {1'b0, ZERO8[2:0]} + 4'd1);
   wire src_rls = ien_r[IEN_RLS] && (oe_r || pe_r || fe_r || bi_r);
   wire src_rda = ien_r[IEN_RDA] && (qen_r ? trig_hit : dr_r);
   wire src_tmo = ien_r[IEN_RDA] && tmo_r;
   wire src_thre = ien_r[IEN_THRE] && thre_ev_r && thr_empty;
   wire src_msi = ien_r[IEN_MSI] && (msr_d_r != '0);
   // with all enables clear no source can pend
   assign iir_code = src_rls ? ID_RLS : src_rda ? ID_RDA : src_tmo ? ID_TMO :
      src_thre ? ID_THRE : src_msi ? ID_MSI : ID_NONE;
   // gate output bit passes the request
   assign irq_out = mcr_r[MCR_GATE] && !iir_code[0];
   assign rts_n_out = !mcr_r[1];
   assign dtr_n_out = !mcr_r[0];

   // ----------------------------------------
   // Read data, registered
   // ----------------------------------------
   wire [7:0] rbuf = qen_r ? rxq_d : rbr_r;
   wire [7:0] msr = {mdm_now, msr_d_r};
   wire [7:0] rd_mux =
      sel_dll ? div_r[7:0] :
      sel_dlm ? div_r[15:8] :
      sel_buf ? rbuf :
      sel_ien ? {4'h0, ien_r} :
      (addr_in == OFS_IDENT) ? {{2{qen_r}}, 2'b00, iir_code} :
      (addr_in == OFS_LCR) ? lcr_r :
      (addr_in == OFS_MCR) ? mcr_r :
      (addr_in == OFS_LSR) ? lsr :
      (addr_in == OFS_MSR) ? msr : scr_r;
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) rdata_r <= ZERO8;
      else if (rd_in) rdata_r <= rd_mux;
   end
   assign rdata_out = rdata_r;
endmodule
`default_nettype wire

// [tb/uartfe_checker.sv]
// Port-level assertion checker for the UART register front end
`timescale 1ns/1ps
`default_nettype none
module uartfe_checker
   import uartfe_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic tx_out,
   input wire logic rx_in,
   input wire logic cts_n_in,
   input wire logic dsr_n_in,
   input wire logic ri_n_in,
   input wire logic dcd_n_in,
   input wire logic rts_n_out,
   input wire logic dtr_n_out,
   input wire logic irq_out
);
   logic [7:0] lcr_r, mcr_r, ien_r, scr_r, dlo_r, dhi_r, low_r;
   // Write decode, split by the divisor latch select bit
   wire divisor_latch_select = lcr_r[LCR_DIVISOR_LATCH_SELECT];
   wire w_lo = wr_in && addr_in == OFS_DATA && divisor_latch_select;
   wire w_hi = wr_in && addr_in == OFS_IEN && divisor_latch_select;
   wire w_ien = wr_in && addr_in == OFS_IEN && !divisor_latch_select;
   wire w_mcr = wr_in && addr_in == OFS_MCR;
   // Shadow copies of host-written registers, same edge as the design
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         {lcr_r, mcr_r, ien_r, scr_r} <= {LCR_RST, ZERO8, ZERO8, ZERO8};
         {dhi_r, dlo_r} <= DIV_RST;
      end else begin
         if (wr_in && addr_in == OFS_LCR) lcr_r <= wdata_in;
         if (wr_in && addr_in == OFS_SCR) scr_r <= wdata_in;
         if (w_mcr) mcr_r <= wdata_in;
         if (w_ien) ien_r <= wdata_in;
         if (w_lo) dlo_r <= wdata_in;
         if (w_hi) dhi_r <= wdata_in;
      end
   end
   // Length of the current low run on the line; bit cells must be whole
   always_ff @(posedge ref_clk_in) begin
      low_r <= (sys_rst_in || tx_out) ? 8'h00 : low_r + 8'h01;
   end
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   rst_idle_a: assert property (disable iff (1'b0) sys_rst_in |=>
      (tx_out && !irq_out && rdata_out == 8'h00)) else $error("reset state wrong");
   irq_gate_a: assert property (!mcr_r[MCR_GATE] |-> !irq_out)
      else $error("interrupt passed while gate bit is low");
   irq_mask_a: assert property (ien_r[3:0] == 4'h0 |-> !irq_out)
      else $error("interrupt with all enables cleared");
   ien_read_a: assert property (rd_in && addr_in == OFS_IEN && !divisor_latch_select |=>
      rdata_out == {4'h0, ien_r[3:0]}) else $error("enable register read wrong");
   div_lo_read_a: assert property (rd_in && addr_in == OFS_DATA && divisor_latch_select |=>
      rdata_out == dlo_r) else $error("divisor low byte read wrong");
   div_hi_read_a: assert property (rd_in && addr_in == OFS_IEN && divisor_latch_select |=>
      rdata_out == dhi_r) else $error("divisor high byte read wrong");
   scratch_read_a: assert property (rd_in && addr_in == OFS_SCR |=>
      rdata_out == scr_r) else $error("scratch read wrong");
   lcr_read_a: assert property (rd_in && addr_in == OFS_LCR |=> rdata_out == lcr_r)
      else $error("line control read wrong");
   bit_cell_a: assert property ($rose(tx_out) && {dhi_r, dlo_r} == 16'h0001 |->
      low_r[3:0] == 4'h0) else $error("serial low run not whole bit cells");
   slow_cell_a: assert property ($rose(tx_out) && {dhi_r, dlo_r} == 16'h0002 |->
      low_r[4:0] == 5'h00) else $error("serial low run not whole cells at divisor two");
   modem_out_a: assert property (w_mcr |-> ##2
      {rts_n_out, dtr_n_out} == ~mcr_r[1:0]) else $error("modem outputs wrong");
   cover property ($rose(irq_out));
   cover property ($rose(tx_out) && low_r == 8'h10);
   cover property (rd_in && divisor_latch_select);
endmodule
bind uartfe_top uartfe_checker u_chk (.ref_clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in,
   .rd_in, .rdata_out, .tx_out, .rx_in, .cts_n_in, .dsr_n_in, .ri_n_in, .dcd_n_in, .rts_n_out,
   .dtr_n_out, .irq_out);
`default_nettype wire

// [tb/uartfe_line_model.sv]
// Serial line and modem partner at the far side of the UART
`timescale 1ns/1ps
`default_nettype none
module uartfe_line_model (
   input wire logic ref_clk_in,
   input wire logic tx_line_in,
   output logic rx_line_out,
   output logic cts_n_out,
   output logic dsr_n_out,
   output logic ri_n_out,
   output logic dcd_n_out
);
   int nbits = 8;
   int clk_per_tick = 1;
   int got_cnt = 0;
   logic [7:0] got [0:7];
   logic [7:0] sh;
   // Line idles at mark, modem lines not asserted
   initial begin
      rx_line_out = 1'b1;
      {cts_n_out, dsr_n_out, ri_n_out, dcd_n_out} = 4'hF;
   end
   // Mid-bit sampling, LSB first, sixteen clocks per bit at divisor one
   initial forever begin
      @(negedge tx_line_in);
      repeat (8 * clk_per_tick) @(posedge ref_clk_in);
      sh = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         repeat (16 * clk_per_tick) @(posedge ref_clk_in);
         sh[i] = tx_line_in;
      end
      repeat (16 * clk_per_tick) @(posedge ref_clk_in);
      got[got_cnt[2:0]] = sh;
      got_cnt++;
   end
   // One start bit, eight data bits LSB first; a zero stop makes a bad frame
   task automatic send_byte(input logic [7:0] b, input logic stop_ok);
      rx_line_out <= 1'b0;
      repeat (16) @(posedge ref_clk_in);
      for (int i = 0; i < 8; i++) begin
         rx_line_out <= b[i];
         repeat (16) @(posedge ref_clk_in);
      end
      rx_line_out <= stop_ok;
      repeat (16) @(posedge ref_clk_in);
      rx_line_out <= 1'b1;
      repeat (16) @(posedge ref_clk_in);
   endtask
   task automatic set_cts(input logic lvl);
      @(posedge ref_clk_in);
      cts_n_out <= lvl;
   endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the UART register front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import uartfe_pkg::*;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic [7:0] v;
   wire logic tx_out, rx_in, cts_n, dsr_n, ri_n, dcd_n, rts_n_out, dtr_n_out, irq_out;
   int miscompares = 0;
   int num_checks = 0;
   always #20 ref_clk_in = ~ref_clk_in;
   uartfe_top u_dut (.ref_clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .tx_out, .rx_in, .cts_n_in(cts_n), .dsr_n_in(dsr_n), .ri_n_in(ri_n),
      .dcd_n_in(dcd_n), .rts_n_out, .dtr_n_out, .irq_out);
   uartfe_line_model u_line (.ref_clk_in, .tx_line_in(tx_out), .rx_line_out(rx_in),
      .cts_n_out(cts_n), .dsr_n_out(dsr_n), .ri_n_out(ri_n), .dcd_n_out(dcd_n));
   // ------------------------------------------------------------
   // Host access and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask
   // Read data is valid just after the edge that takes the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   task automatic rdchk(input string what, input logic [2:0] a, input logic [7:0] m,
         input logic [7:0] exp);
      rd(a, v);
      chk(what, exp, v & m);
   endtask
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      #1;
      while (irq_out !== lvl && n < 400) begin
         @(posedge ref_clk_in);
         #1 n++;
      end
      chk("irq_out", {7'h00, lvl}, {7'h00, irq_out});
   endtask
   // Bounded wait on the line partner's count of received characters
   task automatic wait_rx(input int cnt);
      for (int k = 0; k < 2000 && u_line.got_cnt < cnt; k++) @(posedge ref_clk_in);
   endtask
   // Poll line status until every bit of the mask is set
   task automatic poll_lsr(input logic [7:0] m);
      v = 8'h00;
      for (int k = 0; k < 200 && (v & m) !== m; k++) rd(OFS_LSR, v);
   endtask
   task automatic final_report();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog: the sequence needs a few thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      miscompares++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rdchk("line ctl reset", OFS_LCR, 8'hFF, LCR_RST);
      rdchk("ident idle", OFS_IDENT, 8'hFF, 8'h01);
      wr(OFS_SCR, 8'hA5);
      rdchk("scratch", OFS_SCR, 8'hFF, 8'hA5);
      wr(OFS_IEN, 8'hFF);
      rdchk("enable upper", OFS_IEN, 8'hFF, 8'h0F);
      wr(OFS_LCR, 8'h83);
      wr(OFS_DATA, 8'h34);
      wr(OFS_IEN, 8'h12);
      rdchk("divisor lo", OFS_DATA, 8'hFF, 8'h34);
      rdchk("divisor hi", OFS_IEN, 8'hFF, 8'h12);
      wr(OFS_DATA, 8'h01);
      wr(OFS_IEN, 8'h00);
      wr(OFS_LCR, 8'h03);
      rdchk("enable kept", OFS_IEN, 8'hFF, 8'h0F);
      wr(OFS_IEN, 8'h00);
      wr(OFS_DATA, 8'h5A);
      poll_lsr(8'h20);
      wr(OFS_DATA, 8'hC3);
      wait_rx(2);
      chk("tx first", 8'h5A, u_line.got[0]);
      chk("tx second", 8'hC3, u_line.got[1]);
      wr(OFS_LCR, 8'h00);
      u_line.nbits = 5;
      wr(OFS_DATA, 8'hF5);
      wait_rx(3);
      chk("tx five bits", 8'h15, u_line.got[2]);
      wr(OFS_LCR, 8'h03);
      u_line.nbits = 8;
      u_line.send_byte(8'h96, 1'b1);
      poll_lsr(8'h01);
      rdchk("rx byte", OFS_DATA, 8'hFF, 8'h96);
      wr(OFS_IEN, 8'h01);
      u_line.send_byte(8'h3C, 1'b1);
      poll_lsr(8'h01);
      wait_irq(1'b0);
      wr(OFS_MCR, 8'h08);
      wait_irq(1'b1);
      wr(OFS_IEN, 8'h00);
      wait_irq(1'b0);
      wr(OFS_IEN, 8'h01);
      wait_irq(1'b1);
      rdchk("rx second", OFS_DATA, 8'hFF, 8'h3C);
      wait_irq(1'b0);
      wr(OFS_IEN, 8'h02);
      wr(OFS_DATA, 8'h11);
      wait_irq(1'b1);
      rdchk("ident empty", OFS_IDENT, 8'h0F, 8'h02);
      wait_irq(1'b0);
      wait_rx(4);
      chk("tx fourth", 8'h11, u_line.got[3]);
      wr(OFS_LCR, 8'h83);
      wr(OFS_DATA, 8'h02);
      wr(OFS_LCR, 8'h03);
      u_line.clk_per_tick = 2;
      wr(OFS_DATA, 8'hA7);
      wait_rx(5);
      chk("tx divisor two", 8'hA7, u_line.got[4]);
      wr(OFS_LCR, 8'h83);
      wr(OFS_DATA, 8'h01);
      wr(OFS_LCR, 8'h03);
      u_line.clk_per_tick = 1;
      wr(OFS_IDENT, 8'h01);
      rdchk("queue mode", OFS_IDENT, 8'hC0, 8'hC0);
      wr(OFS_DATA, 8'h21);
      wr(OFS_DATA, 8'h43);
      wr(OFS_DATA, 8'h65);
      wait_rx(8);
      chk("queue first", 8'h21, u_line.got[5]);
      chk("queue second", 8'h43, u_line.got[6]);
      chk("queue third", 8'h65, u_line.got[7]);
      wr(OFS_IDENT, 8'h00);
      wr(OFS_IEN, 8'h08);
      rd(OFS_MSR, v);
      u_line.set_cts(1'b0);
      wait_irq(1'b1);
      rdchk("modem delta", OFS_MSR, 8'h01, 8'h01);
      wait_irq(1'b0);
      wr(OFS_IEN, 8'h04);
      u_line.send_byte(8'h42, 1'b0);
      wait_irq(1'b1);
      rdchk("framing flag", OFS_LSR, 8'h08, 8'h08);
      wait_irq(1'b0);
      wr(OFS_MCR, 8'h0B);
      repeat (4) @(posedge ref_clk_in);
      final_report();
   end
endmodule
`default_nettype wire
